// ==== icn_pkg.sv ====
package icn_pkg;

    // Far device identity and its register map
    localparam logic [6:0] DEV_ADDR      = 7'h75;
    localparam logic       DIR_WRITE     = 1'h0;
    localparam logic       DIR_READ      = 1'h1;
    // Fast-mode entry code; the three low bits are don't-care
    localparam logic [7:0] HS_CODE       = 8'h08;
    localparam logic [7:0] DREG_MISC     = 8'h01;
    localparam logic [7:0] DREG_FLOOR    = 8'h02;
    localparam logic [7:0] DREG_ROOF     = 8'h03;
    localparam logic [7:0] DREG_ILIM     = 8'h04;
    localparam logic [7:0] DREG_STATUS   = 8'h05;
    localparam logic [7:0] DREG_NVM_CTRL = 8'hFF;
    localparam logic [7:0] NVM_CTRL_RST  = 8'h00;
    localparam logic [7:0] NVM_STORE_ALL = 8'hC0;

    // Host register file
    localparam logic [2:0] HREG_CTRL     = 3'h0;
    localparam logic [2:0] HREG_PTR      = 3'h1;
    localparam logic [2:0] HREG_WDATA    = 3'h2;
    localparam logic [2:0] HREG_RDATA    = 3'h3;
    localparam logic [2:0] HREG_STATUS   = 3'h4;
    localparam int         CTRL_OP_LSB   = 0;
    localparam int         CTRL_HS_BIT   = 2;
    localparam int         CTRL_SPD_LSB  = 4;
    localparam int         SB_BUSY       = 0;
    localparam int         SB_NACK       = 1;
    localparam int         SB_HS         = 2;
    localparam int         SB_SCL        = 3;
    localparam int         SB_SDA        = 4;
    localparam logic [7:0] PTR_RST       = 8'h00;
    localparam logic [7:0] WDATA_RST     = 8'h00;

    localparam logic [1:0] OP_WRITE      = 2'h0;
    localparam logic [1:0] OP_READ       = 2'h1;
    localparam logic [1:0] OP_STORE      = 2'h2;
    localparam logic [1:0] OP_BUSRST     = 2'h3;
    localparam logic [1:0] SPD_STD       = 2'h0;
    localparam logic [1:0] SPD_FAST      = 2'h1;

    // Sequence positions
    localparam logic [3:0] MC_STEPS      = 4'h2;
    localparam logic [3:0] STEP_MC       = 4'h1;
    localparam logic [3:0] B_OPEN        = 4'h0;
    localparam logic [3:0] B_DEVW        = 4'h1;
    localparam logic [3:0] B_PTR         = 4'h2;
    localparam logic [3:0] B_DATA        = 4'h3;
    localparam logic [3:0] B_STOP_W      = 4'h4;
    localparam logic [3:0] B_RS          = 4'h3;
    localparam logic [3:0] B_DEVR        = 4'h4;
    localparam logic [3:0] B_RX          = 4'h5;
    localparam logic [3:0] B_STOP_R      = 4'h6;
    localparam logic [3:0] STEP_ABORT    = 4'hE;
    localparam logic [3:0] BIT_ACK       = 4'h8;
    localparam logic [1:0] PH_HOLD       = 2'h0;
    localparam logic [1:0] PH_SAMPLE     = 2'h2;
    localparam logic [1:0] PH_LAST       = 2'h3;

    // Timing: bit periods in ps, quarters rounded up to clocks
    localparam int CLK_PS   = 4000;
    localparam int T_STD_PS = 10000000;
    localparam int T_FST_PS = 2500000;
    localparam int T_FPL_PS = 1000000;
    localparam int T_HS_PS  = 294118;
    localparam int QDIV     = 4 * CLK_PS;
    localparam logic [9:0] QC_STD = 10'((T_STD_PS + QDIV - 1) / QDIV);
    localparam logic [9:0] QC_FST = 10'((T_FST_PS + QDIV - 1) / QDIV);
    localparam logic [9:0] QC_FPL = 10'((T_FPL_PS + QDIV - 1) / QDIV);
    localparam logic [9:0] QC_HS  = 10'((T_HS_PS + QDIV - 1) / QDIV);

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_FETCH = 4'h2,
        ST_COND  = 4'h4,
        ST_BIT   = 4'h8
    } icn_state_e;

    typedef enum logic [2:0] {
        ACT_START  = 3'h0,
        ACT_RSTART = 3'h1,
        ACT_TX     = 3'h2,
        ACT_RX     = 3'h3,
        ACT_STOP   = 3'h4,
        ACT_DONE   = 3'h5
    } icn_act_e;

endpackage : icn_pkg

// ==== icn_host.sv ====
// Operation
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Data changes only while clock low
// - Eight data bits then one acknowledge
// - Master code at fast rate, unacknowledged; sent at standard rate when SPD_STD is set
// - Repeated start keeps fast; stop ends it
// - Chain with repeated starts to stay fast
// - Update: address, pointer, data, all acknowledged
// - Write C0h to FFh stores configuration
// - Master issues stop after bus power-up; here only on an OP_BUSRST command
`timescale 1ns/1ps
module icn_host (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [2:0] addr_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rd_data_out,
    output logic            busy_out,
    input  wire logic       scl_in,
    output logic            scl_drv_out,
    output logic            scl_oe_out,
    input  wire logic       sda_in,
    output logic            sda_drv_out,
    output logic            sda_oe_out
);

    function automatic icn_pkg::icn_act_e step_act(
        input logic [1:0] op,
        input logic       hs,
        input logic [3:0] step
    );
        logic [3:0] b;
        b = hs ? 4'(step - icn_pkg::MC_STEPS) : step;
        if (step == icn_pkg::STEP_ABORT)
            return icn_pkg::ACT_STOP;
        if (step > icn_pkg::STEP_ABORT)
            return icn_pkg::ACT_DONE;
        if (op == icn_pkg::OP_BUSRST)
            return (step == icn_pkg::B_OPEN) ? icn_pkg::ACT_STOP
                                             : icn_pkg::ACT_DONE;
        if (hs && step == icn_pkg::B_OPEN)
            return icn_pkg::ACT_START;
        if (hs && step == icn_pkg::STEP_MC)
            return icn_pkg::ACT_TX;
        if (b == icn_pkg::B_OPEN)
            return hs ? icn_pkg::ACT_RSTART : icn_pkg::ACT_START;
        if (b == icn_pkg::B_DEVW || b == icn_pkg::B_PTR)
            return icn_pkg::ACT_TX;
        if (op != icn_pkg::OP_READ)
        begin
            if (b == icn_pkg::B_DATA)
                return icn_pkg::ACT_TX;
            if (b == icn_pkg::B_STOP_W)
                return icn_pkg::ACT_STOP;
            return icn_pkg::ACT_DONE;
        end
        if (b == icn_pkg::B_RS)
            return icn_pkg::ACT_RSTART;
        if (b == icn_pkg::B_DEVR)
            return icn_pkg::ACT_TX;
        if (b == icn_pkg::B_RX)
            return icn_pkg::ACT_RX;
        if (b == icn_pkg::B_STOP_R)
            return icn_pkg::ACT_STOP;
        return icn_pkg::ACT_DONE;
    endfunction : step_act

    icn_pkg::icn_state_e state_reg;
    icn_pkg::icn_act_e   act_reg;
    icn_pkg::icn_act_e   act_w;
    logic [1:0]          op_reg;
    logic                cmd_hs_reg;
    logic [1:0]          spd_reg;
    logic [7:0]          ptr_reg;
    logic [7:0]          wdata_reg;
    logic [7:0]          rdata_reg;
    logic                nack_reg;
    logic                hs_reg;
    logic [3:0]          step_reg;
    logic [3:0]          bit_reg;
    logic [1:0]          ph_reg;
    logic [9:0]          q_cnt_reg;
    logic [7:0]          sh_reg;
    logic                ack_reg;
    logic                scl_s1_reg;
    logic                scl_s2_reg;
    logic                sda_s1_reg;
    logic                sda_s2_reg;
    logic                scl_low_reg;
    logic                sda_low_reg;
    logic [7:0]          rd_data_reg;

    logic                eff_hs_w;
    logic [3:0]          body_w;
    logic                is_mc_w;
    logic                store_w;
    logic [7:0]          tx_byte_w;
    logic                cap_w;
    logic [9:0]          q_len_w;
    logic                q_last_w;
    logic                in_eng_w;
    logic                ph_end_w;
    logic                unit_end_w;
    logic                is_tx_w;
    logic                scl_low_w;
    logic                sda_low_w;
    logic                upd_scl_w;
    logic                upd_sda_w;
    logic                ctrl_wr_w;
    logic [7:0]          ctrl_rb_w;
    logic [7:0]          status_w;
    logic [7:0]          rd_mux_w;

    // Bus-reset sequence ignores the fast-mode request
    assign eff_hs_w  = cmd_hs_reg && op_reg != icn_pkg::OP_BUSRST;
    assign body_w    = eff_hs_w ? 4'(step_reg - icn_pkg::MC_STEPS)
                                : step_reg;
    assign is_mc_w   = eff_hs_w && step_reg == icn_pkg::STEP_MC;
    assign store_w   = op_reg == icn_pkg::OP_STORE;
    assign act_w     = step_act(op_reg, cmd_hs_reg, step_reg);

    // Byte on the wire for each transmit position
    assign tx_byte_w =
        is_mc_w                   ? icn_pkg::HS_CODE :
        body_w == icn_pkg::B_DEVW ? {icn_pkg::DEV_ADDR,
                                     icn_pkg::DIR_WRITE} :
        body_w == icn_pkg::B_PTR  ? (store_w ? icn_pkg::DREG_NVM_CTRL
                                             : ptr_reg) :
        body_w == icn_pkg::B_DEVR ? {icn_pkg::DEV_ADDR,
                                     icn_pkg::DIR_READ} :
        store_w                   ? icn_pkg::NVM_STORE_ALL
                                  : wdata_reg;

    // Master code always goes at fast rate or slower
    assign cap_w   = eff_hs_w && !hs_reg;
    assign q_len_w = hs_reg                        ? icn_pkg::QC_HS :
                     spd_reg == icn_pkg::SPD_STD   ? icn_pkg::QC_STD :
                     spd_reg == icn_pkg::SPD_FAST || cap_w
                                                   ? icn_pkg::QC_FST
                                                   : icn_pkg::QC_FPL;

    assign q_last_w   = q_cnt_reg == '0;
    assign in_eng_w   = state_reg == icn_pkg::ST_COND
                     || state_reg == icn_pkg::ST_BIT;
    assign ph_end_w   = in_eng_w && q_last_w;
    assign unit_end_w = ph_end_w && ph_reg == icn_pkg::PH_LAST
                     && (state_reg == icn_pkg::ST_COND
                         || bit_reg == icn_pkg::BIT_ACK);
    assign is_tx_w    = act_reg == icn_pkg::ACT_TX;

    // Line drive per phase; clock high in the back half, and all through a start
    always_comb
    begin
        scl_low_w = 1'b0;
        sda_low_w = 1'b0;
        if (state_reg == icn_pkg::ST_BIT)
        begin
            scl_low_w = ph_reg < icn_pkg::PH_SAMPLE;
            sda_low_w = is_tx_w && bit_reg != icn_pkg::BIT_ACK
                     && !sh_reg[7];
        end
        else if (state_reg == icn_pkg::ST_COND)
        begin
            unique case (act_reg)
                icn_pkg::ACT_START:
                begin
                    sda_low_w = ph_reg == icn_pkg::PH_LAST;
                end
                icn_pkg::ACT_RSTART:
                begin
                    scl_low_w = ph_reg < icn_pkg::PH_SAMPLE;
                    sda_low_w = ph_reg == icn_pkg::PH_LAST;
                end
                default:
                begin
                    scl_low_w = ph_reg < icn_pkg::PH_SAMPLE;
                    sda_low_w = ph_reg < icn_pkg::PH_LAST;
                end
            endcase
        end
    end

    // Data held through the first quarter after clock falls
    assign upd_scl_w = state_reg == icn_pkg::ST_IDLE || in_eng_w;
    assign upd_sda_w = state_reg == icn_pkg::ST_IDLE
                    || (state_reg == icn_pkg::ST_COND
                        && ph_reg != icn_pkg::PH_HOLD)
                    || (state_reg == icn_pkg::ST_BIT
                        && ph_reg != icn_pkg::PH_HOLD
                        && ph_reg < icn_pkg::PH_SAMPLE);

    assign ctrl_wr_w = wr_in && addr_in == icn_pkg::HREG_CTRL
                    && state_reg == icn_pkg::ST_IDLE;

    assign ctrl_rb_w = {2'h0, spd_reg, 1'b0, cmd_hs_reg, op_reg};
    always_comb
    begin
        status_w = '0;
        status_w[icn_pkg::SB_BUSY] = state_reg != icn_pkg::ST_IDLE;
        status_w[icn_pkg::SB_NACK] = nack_reg;
        status_w[icn_pkg::SB_HS]   = hs_reg;
        status_w[icn_pkg::SB_SCL]  = scl_s2_reg;
        status_w[icn_pkg::SB_SDA]  = sda_s2_reg;
    end

    assign rd_mux_w = addr_in == icn_pkg::HREG_CTRL   ? ctrl_rb_w :
                      addr_in == icn_pkg::HREG_PTR    ? ptr_reg :
                      addr_in == icn_pkg::HREG_WDATA  ? wdata_reg :
                      addr_in == icn_pkg::HREG_RDATA  ? rdata_reg :
                      addr_in == icn_pkg::HREG_STATUS ? status_w : 8'h00;

    // Pin synchronisers; clock is sampled only for status
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
        end
        else
        begin
            scl_s1_reg <= scl_in;
            scl_s2_reg <= scl_s1_reg;
            sda_s1_reg <= sda_in;
            sda_s2_reg <= sda_s1_reg;
        end
    end

    // Software port
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ptr_reg     <= icn_pkg::PTR_RST;
            wdata_reg   <= icn_pkg::WDATA_RST;
            rd_data_reg <= 8'h00;
        end
        else
        begin
            if (wr_in && addr_in == icn_pkg::HREG_PTR)
                ptr_reg <= wr_data_in;
            if (wr_in && addr_in == icn_pkg::HREG_WDATA)
                wdata_reg <= wr_data_in;
            rd_data_reg <= rd_in ? rd_mux_w : 8'h00;
        end
    end

    // Sequencer
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg  <= icn_pkg::ST_IDLE;
            act_reg    <= icn_pkg::ACT_DONE;
            op_reg     <= icn_pkg::OP_WRITE;
            cmd_hs_reg <= 1'b0;
            spd_reg    <= icn_pkg::SPD_STD;
            step_reg   <= '0;
            nack_reg   <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                icn_pkg::ST_IDLE:
                begin
                    if (ctrl_wr_w)
                    begin
                        op_reg     <= wr_data_in[icn_pkg::CTRL_OP_LSB +: 2];
                        cmd_hs_reg <= wr_data_in[icn_pkg::CTRL_HS_BIT];
                        spd_reg    <= wr_data_in[icn_pkg::CTRL_SPD_LSB +: 2];
                        step_reg   <= '0;
                        nack_reg   <= 1'b0;
                        state_reg  <= icn_pkg::ST_FETCH;
                    end
                end
                icn_pkg::ST_FETCH:
                begin
                    act_reg <= act_w;
                    if (act_w == icn_pkg::ACT_DONE)
                        state_reg <= icn_pkg::ST_IDLE;
                    else if (act_w == icn_pkg::ACT_TX
                             || act_w == icn_pkg::ACT_RX)
                        state_reg <= icn_pkg::ST_BIT;
                    else
                        state_reg <= icn_pkg::ST_COND;
                end
                default:
                begin
                    if (unit_end_w)
                    begin
                        state_reg <= icn_pkg::ST_FETCH;
                        step_reg  <= 4'(step_reg + 4'h1);
                        // Missing acknowledge: abandon with a stop
                        if (is_tx_w && !is_mc_w && ack_reg
                            && state_reg == icn_pkg::ST_BIT)
                        begin
                            nack_reg <= 1'b1;
                            step_reg <= icn_pkg::STEP_ABORT;
                        end
                    end
                end
            endcase
        end
    end

    // Bit engine
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            q_cnt_reg <= '0;
            ph_reg    <= icn_pkg::PH_HOLD;
            bit_reg   <= '0;
            sh_reg    <= 8'h00;
            ack_reg   <= 1'b1;
        end
        else if (state_reg == icn_pkg::ST_FETCH)
        begin
            q_cnt_reg <= 10'(q_len_w - 10'h1);
            ph_reg    <= icn_pkg::PH_HOLD;
            bit_reg   <= '0;
            sh_reg    <= tx_byte_w;
        end
        else if (ph_end_w)
        begin
            q_cnt_reg <= 10'(q_len_w - 10'h1);
            ph_reg    <= 2'(ph_reg + 2'h1);
            if (state_reg == icn_pkg::ST_BIT
                && ph_reg == icn_pkg::PH_SAMPLE)
            begin
                if (bit_reg == icn_pkg::BIT_ACK)
                    ack_reg <= sda_s2_reg;
                else
                    sh_reg <= {sh_reg[6:0], sda_s2_reg};
            end
            if (state_reg == icn_pkg::ST_BIT
                && ph_reg == icn_pkg::PH_LAST)
                bit_reg <= 4'(bit_reg + 4'h1);
        end
        else if (in_eng_w)
            q_cnt_reg <= 10'(q_cnt_reg - 10'h1);
    end

    // Speed mode and read result
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            hs_reg    <= 1'b0;
            rdata_reg <= 8'h00;
        end
        else if (unit_end_w)
        begin
            if (is_mc_w && state_reg == icn_pkg::ST_BIT)
                hs_reg <= 1'b1;
            if (act_reg == icn_pkg::ACT_STOP)
                hs_reg <= 1'b0;
            if (act_reg == icn_pkg::ACT_RX)
                rdata_reg <= sh_reg;
        end
    end

    // Open-drain drive; lines are only pulled low, and a device holding the clock is not waited for
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            scl_low_reg <= 1'b0;
            sda_low_reg <= 1'b0;
        end
        else
        begin
            if (upd_scl_w)
                scl_low_reg <= scl_low_w;
            if (upd_sda_w)
                sda_low_reg <= sda_low_w;
        end
    end

    assign scl_drv_out = 1'b0;
    assign sda_drv_out = 1'b0;
    assign scl_oe_out  = scl_low_reg;
    assign sda_oe_out  = sda_low_reg;
    assign busy_out    = state_reg != icn_pkg::ST_IDLE;
    assign rd_data_out = rd_data_reg;

endmodule : icn_host

// ==== icn_asserts.sv ====
`timescale 1ns/1ps
module icn_asserts (
    input wire logic       sys_clk_in,
    input wire logic       rst_n_in,
    input wire logic [2:0] addr_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rd_data_out,
    input wire logic       busy_out,
    input wire logic       scl_drv_out,
    input wire logic       scl_oe_out,
    input wire logic       sda_drv_out,
    input wire logic       sda_oe_out
);
    // Clocks of SCL held low, to bound the fastest rate
    logic [9:0] low_cnt;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
        if (!rst_n_in)
            low_cnt <= 10'h000;
        else
            low_cnt <= scl_oe_out ? low_cnt + 10'h001 : 10'h000;
    a_start_clock: assert property (
        $rose(sda_oe_out) && !scl_oe_out |-> ##[1:700] scl_oe_out)
        else $error("no clock after start");
    a_stop_idle: assert property (
        $fell(sda_oe_out) && !scl_oe_out |-> ##[1:700] !busy_out)
        else $error("stop not followed by idle");
    a_hold_fall: assert property (
        $rose(scl_oe_out) |-> $stable(sda_oe_out))
        else $error("data moved as clock fell");
    a_hold_rise: assert property (
        $fell(scl_oe_out) |-> $stable(sda_oe_out))
        else $error("data moved as clock rose");
    // Two high-speed quarters is the shortest legal low phase
    a_low_time: assert property (
        $fell(scl_oe_out) |-> low_cnt >= 10'h026)
        else $error("clock low phase too short");
    a_idle_free: assert property (
        (!busy_out)[*3] |-> !scl_oe_out && !sda_oe_out)
        else $error("bus held while idle");
    a_open_drain: assert property (
        scl_drv_out == 1'b0 && sda_drv_out == 1'b0)
        else $error("line driven high");
    a_busy_start: assert property (
        wr_in && addr_in == icn_pkg::HREG_CTRL && !busy_out |=> busy_out)
        else $error("command did not start");
    a_rd_quiet: assert property ( // Read data only after a strobe
        !$past(rd_in) |-> rd_data_out == 8'h00)
        else $error("read data outside its cycle");
    c_start: cover property ($rose(sda_oe_out) && !scl_oe_out);
    c_done: cover property ($fell(busy_out));
    c_read: cover property (rd_in && addr_in == icn_pkg::HREG_RDATA);
endmodule : icn_asserts

bind icn_host icn_asserts i_icn_asserts (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
    .busy_out(busy_out), .scl_drv_out(scl_drv_out),
    .scl_oe_out(scl_oe_out), .sda_drv_out(sda_drv_out),
    .sda_oe_out(sda_oe_out)
);

// ==== icn_dev_model.sv ====
`timescale 1ns/1ps
// Behavioural device; rate-free, so any bit rate is taken
module icn_dev_model #(
    parameter int WP_B  = 4,
    parameter int SEL_B = 0
) (
    input  wire logic scl_in,     // Never driven here
    input  wire logic sda_in,
    input  wire logic absent_in,  // Port held off, as under lockout
    output logic      sda_oe_out
);
    logic [7:0] vol [1:5];
    logic [7:0] nv [1:5] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25};
    logic [7:0] ctl = 8'h00;
    logic [7:0] sh = 8'h00;
    logic [7:0] ptr = 8'h00;
    logic [7:0] tx = 8'h00;
    logic       act = 1'b0;
    logic       rdm = 1'b0;
    logic       nak = 1'b0;
    int         bc = 0;
    int         bi = 0;
    initial sda_oe_out = 1'b0;
    initial vol = nv;
    function automatic logic [7:0] rdv(input logic [7:0] a);
        if (a == 8'hFF)
            return ctl;
        if (a < 8'h01 || a > 8'h05)
            return 8'h00;
        return ctl[SEL_B] ? nv[a[2:0]] : vol[a[2:0]];
    endfunction : rdv
    task automatic put(input logic [7:0] d);
        if (ptr == 8'hFF)
            ctl = d;
        if (ptr == 8'hFF && d == 8'hC0 && !nv[1][WP_B])
            nv = vol;
        if (ptr >= 8'h01 && ptr <= 8'h04 && !ctl[SEL_B])
            vol[ptr[2:0]] = d;
        if (ptr >= 8'h01 && ptr <= 8'h04 && ctl[SEL_B] && !nv[1][WP_B])
            nv[ptr[2:0]] = d;
    endtask : put
    always @(negedge sda_in)
        if (scl_in)
        begin
            act = !absent_in;
            bc = -1; // The fall after a start carries no bit
            bi = 0;
            rdm = 1'b0;
        end
    always @(posedge sda_in)
        if (scl_in)
        begin
            act = 1'b0;
            sda_oe_out = 1'b0;
        end
    always @(posedge scl_in)
        if (bc == 8)
            nak = sda_in;
        else
            sh = {sh[6:0], sda_in};
    always @(negedge scl_in)
    begin
        if (act && bc < 7)
        begin
            bc++;
            if (rdm && bi > 0)
                sda_oe_out = !tx[7 - bc];
        end
        else if (act && bc == 7)
        begin
            bc = 8;
            sda_oe_out = !(rdm && bi > 0);
            if (bi == 0)
            begin
                rdm = sh[0];
                act = sh[7:1] == 7'h75;
                sda_oe_out = act;
            end
        end
        else if (act && bc == 8)
        begin
            sda_oe_out = 1'b0;
            bc = 0;
            bi++;
            if (!rdm && bi == 2)
                ptr = sh;
            if (!rdm && bi == 3)
                put(sh);
            if (rdm && nak)
                act = 1'b0;
            if (rdm && act)
            begin
                tx = rdv(ptr);
                sda_oe_out = !tx[7];
            end
        end
    end
endmodule : icn_dev_model

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       absent = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdat = 8'h00;
    wire  [7:0] rdat;
    wire        busy, scl_oe, sda_oe, dev_oe, scl, sda;
    int         fails = 0;
    int         n_tests = 0;
    // Pull-ups: a line is low while any party enables its driver
    assign scl = !scl_oe;
    assign sda = !sda_oe && !dev_oe;
    icn_host i_icn_host (
        .sys_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr),
        .wr_data_in(wdat), .wr_in(wr), .rd_in(rd), .rd_data_out(rdat),
        .busy_out(busy), .scl_in(scl), .scl_drv_out(),
        .scl_oe_out(scl_oe), .sda_in(sda), .sda_drv_out(),
        .sda_oe_out(sda_oe)
    );
    icn_dev_model i_icn_dev_model (
        .scl_in(scl), .sda_in(sda), .absent_in(absent),
        .sda_oe_out(dev_oe)
    );
    initial
        forever #2 clk = !clk;
    task automatic stop_test;
        if (fails == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("host register", rdat, exp);
    endtask : rd_chk
    // Pointer and data stay put while busy, as the host reads them live
    task automatic op(input logic [7:0] p, d, c);
        int n;
        n = 0;
        wr_reg(icn_pkg::HREG_PTR, p);
        wr_reg(icn_pkg::HREG_WDATA, d);
        wr_reg(icn_pkg::HREG_CTRL, c);
        #1;
        while (busy !== 1'b0 && n < 30000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 30000)
            fails++;
    endtask : op
    initial
    begin
        #360000;
        fails++;
        stop_test();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(icn_pkg::HREG_CTRL, 8'h00);
        rd_chk(3'h5, 8'h00);
        op(8'h00, 8'h00, 8'h23);
        rd_chk(icn_pkg::HREG_STATUS, 8'h18);
        op(8'h02, 8'hA5, 8'h20);
        chk("vol2", i_icn_dev_model.vol[2], 8'hA5);
        rd_chk(icn_pkg::HREG_STATUS, 8'h18);
        op(8'h02, 8'h00, 8'h21);
        rd_chk(icn_pkg::HREG_RDATA, 8'hA5);
        op(8'h05, 8'h00, 8'h21);
        rd_chk(icn_pkg::HREG_RDATA, 8'h25);
        op(8'h06, 8'h00, 8'h21);
        rd_chk(icn_pkg::HREG_RDATA, 8'h00);
        op(8'h00, 8'h00, 8'h22);
        chk("nv2", i_icn_dev_model.nv[2], 8'hA5);
        chk("ctl", i_icn_dev_model.ctl, 8'hC0);
        op(8'h03, 8'h3C, 8'h24);
        chk("vol3", i_icn_dev_model.vol[3], 8'h3C);
        op(8'h03, 8'h00, 8'h25);
        rd_chk(icn_pkg::HREG_RDATA, 8'h3C);
        rd_chk(icn_pkg::HREG_STATUS, 8'h18);
        absent <= 1'b1;
        op(8'h02, 8'h77, 8'h20);
        rd_chk(icn_pkg::HREG_STATUS, 8'h1A);
        chk("vol2", i_icn_dev_model.vol[2], 8'hA5);
        absent <= 1'b0;
        op(8'h02, 8'h77, 8'h20);
        chk("vol2", i_icn_dev_model.vol[2], 8'h77);
        rd_chk(icn_pkg::HREG_STATUS, 8'h18);
        rd_chk(icn_pkg::HREG_CTRL, 8'h20);
        stop_test();
    end
endmodule : tb
